// ### design/tbsl_params.svh
`ifndef TBSL_PARAMS_SVH
`define TBSL_PARAMS_SVH

`define TBSL_ADDR_CTRL      12'h000
`define TBSL_ADDR_STATUS    12'h004
`define TBSL_ADDR_RXWORD    12'h008

`define TBSL_CTRL_RESET     32'h0000_0079
`define TBSL_CTRL_EDGE      0
`define TBSL_CTRL_SYNC_A    1
`define TBSL_CTRL_SYNC_B    2
`define TBSL_CTRL_DEN       3
`define TBSL_CTRL_TX_WAKE   4
`define TBSL_CTRL_RX_WAKE   5
`define TBSL_CTRL_RX_OE     6
`define TBSL_CTRL_STB_POL   7

`define TBSL_STAT_TX_READY  0
`define TBSL_STAT_TX_SYNC   1
`define TBSL_STAT_REF_LOCK  2
`define TBSL_STAT_RX_LOCK   3
`define TBSL_STAT_IGNORE    4
`define TBSL_STAT_CNT_LSB   16

`define TBSL_INIT_WORDS     1024
`define TBSL_SYNC_MIN       1024
`define TBSL_SYNC_IGNORE    5
`define TBSL_REF_EDGES      64
`define TBSL_LOCK_FRAMES    8
`define TBSL_LOSS_CYCLES    64
`define TBSL_STB_CYCLES     2
`define TBSL_FRAME_CYCLES   6

`define TBSL_SYNC_FRAME     12'h03F
`define TBSL_SYNC_WORD      10'h01F

`endif

// ### design/tbsl_pkg.sv
package tbsl_pkg;

   typedef struct packed {
      logic       stb_pol;
      logic       rx_oe;
      logic       rx_wake;
      logic       tx_wake;
      logic       line_driver_enable;
      logic       sync_b;
      logic       sync_a;
      logic       edge_sel;
   } tbsl_ctrl_t;

   typedef struct packed {
      logic [3:0] cnt;
      logic       prev;
      logic [9:0] data;
      logic       done;
      logic       bad;
   } tbsl_rx_t;

   typedef enum logic [3:0] {
      RX_DOWN   = 4'b0001,
      RX_REF    = 4'b0010,
      RX_HUNT   = 4'b0100,
      RX_LOCKED = 4'b1000
   } tbsl_rx_state_t;

endpackage

// ### design/tbsl_top.sv
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "tbsl_params.svh"

module tbsl_top
   import tbsl_pkg::*;
#(
   parameter int INIT_WORDS  = `TBSL_INIT_WORDS,
   parameter int SYNC_MIN    = `TBSL_SYNC_MIN,
   parameter int SYNC_IGNORE = `TBSL_SYNC_IGNORE,
   parameter int REF_EDGES   = `TBSL_REF_EDGES,
   parameter int LOCK_FRAMES = `TBSL_LOCK_FRAMES,
   parameter int LOSS_CYCLES = `TBSL_LOSS_CYCLES
) (
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output var  logic [31:0] prdata_o,
   output var  logic        pready_o,
   output var  logic        pslverr_o,
   input  wire logic        tx_word_clock_i,
   input  wire logic [9:0]  parallel_input_word_i,
   output var  logic [1:0]  serial_pos_o,
   output var  logic [1:0]  serial_neg_o,
   output var  logic        serial_oe_o,
   input  wire logic        local_reference_clock_i,
   input  wire logic [1:0]  serial_in_i,
   output var  logic [9:0]  parallel_output_word_o,
   output var  logic        word_strobe_o,
   output var  logic        rx_data_oe_o,
   output var  logic        lock_n_o,
   output var  logic        lock_oe_o
);

   generate
      if (INIT_WORDS < 1 || INIT_WORDS > 2047 || SYNC_MIN < 1
          || SYNC_MIN > 2047 || SYNC_IGNORE < 1 || SYNC_IGNORE > 7
          || REF_EDGES < 1 || REF_EDGES > 255 || LOCK_FRAMES < 1
          || LOCK_FRAMES > 15 || LOSS_CYCLES < 16
          || LOSS_CYCLES > 255) begin : g_bad_param
         $error("tbsl_top: parameter out of supported range");
      end
   endgenerate

   localparam logic [10:0] INIT_W  = 11'(INIT_WORDS);
   localparam logic [10:0] SMIN_W  = 11'(SYNC_MIN);
   localparam logic [2:0]  IGN_W   = 3'(SYNC_IGNORE);
   localparam logic [7:0]  REF_W   = 8'(REF_EDGES);
   localparam logic [3:0]  LOCK_W  = 4'(LOCK_FRAMES);
   localparam logic [7:0]  LOSS_W  = 8'(LOSS_CYCLES);
   localparam logic [1:0]  STB_W   = 2'(`TBSL_STB_CYCLES);
   localparam logic [2:0]  FRAME_W = 3'(`TBSL_FRAME_CYCLES);

   // Per-bit receive step; applied twice a cycle for the bit pair
   function automatic tbsl_rx_t rx_step(input tbsl_rx_t s,
                                         input logic b);
      tbsl_rx_t r;
      r = s;
      r.done = 1'b0;
      r.bad = 1'b0;
      r.prev = b;
      if (s.cnt == 4'd0) begin
         if (!s.prev && b) begin
            r.cnt = 4'd1;
         end
      end else if (s.cnt <= 4'd10) begin
         r.data = {b, s.data[9:1]};
         r.cnt = s.cnt + 4'd1;
      end else begin
         r.cnt = 4'd0;
         r.done = !b;
         r.bad = b;
      end
      return r;
   endfunction

   // Two-flop synchronisers for every pin from outside the clock
   localparam int NSYNC = 14;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] pin_s1_r;
   logic [NSYNC-1:0] pin_s2_r;
   assign pin_raw = {serial_in_i, local_reference_clock_i,
                     tx_word_clock_i, parallel_input_word_i};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge core_clk_i) begin
            if (reset_i) begin
               pin_s1_r[gi] <= 1'b0;
               pin_s2_r[gi] <= 1'b0;
            end else begin
               pin_s1_r[gi] <= pin_raw[gi];
               pin_s2_r[gi] <= pin_s1_r[gi];
            end
         end
      end
   endgenerate

   wire logic [9:0] din_s    = pin_s2_r[9:0];
   wire logic       wclk_s   = pin_s2_r[10];
   wire logic       rclk_s   = pin_s2_r[11];
   wire logic [1:0] ser_in_s = pin_s2_r[13:12];

   logic wclk_d_r;
   logic rclk_d_r;
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         wclk_d_r <= 1'b0;
         rclk_d_r <= 1'b0;
      end else begin
         wclk_d_r <= wclk_s;
         rclk_d_r <= rclk_s;
      end
   end
   wire logic wclk_rise = wclk_s & ~wclk_d_r;
   wire logic wclk_fall = ~wclk_s & wclk_d_r;
   wire logic rclk_rise = rclk_s & ~rclk_d_r;

   // APB slave: zero wait, answer registered from the setup cycle
   tbsl_ctrl_t  ctrl_r;
   logic [31:0] status_w;
   logic [9:0]  rx_last_r;
   wire logic   hit_ctrl = paddr_i == `TBSL_ADDR_CTRL;
   wire logic   hit_stat = paddr_i == `TBSL_ADDR_STATUS;
   wire logic   hit_word = paddr_i == `TBSL_ADDR_RXWORD;
   wire logic   hit_any  = hit_ctrl | hit_stat | hit_word;
   wire logic   setup    = psel_i & ~penable_i;
   wire logic   wr_ctrl  = psel_i & penable_i & pready_o & pwrite_i
                           & hit_ctrl;
   wire logic [31:0] rd_mux = hit_ctrl ? {24'h00_0000, ctrl_r} :
                              hit_stat ? status_w :
                              hit_word ? {22'h00_0000, rx_last_r} :
                              32'h0000_0000;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         ctrl_r    <= tbsl_ctrl_t'(`TBSL_CTRL_RESET);
      end else begin
         pready_o  <= setup;
         pslverr_o <= setup & ~hit_any;
         prdata_o  <= (setup & ~pwrite_i) ? rd_mux : 32'h0000_0000;
         if (wr_ctrl) begin
            ctrl_r <= tbsl_ctrl_t'(pwdata_i[7:0]);
         end
      end
   end

   // Serializer
   logic [10:0] init_cnt_r;
   logic [2:0]  hold_cnt_r;
   logic [10:0] sent_cnt_r;
   logic        sync_act_r;
   logic [11:0] tx_sh_r;
   logic [2:0]  busy_cnt_r;
   wire logic sync_req  = ctrl_r.sync_a | ctrl_r.sync_b;
   wire logic tx_ready  = init_cnt_r == 11'd0;
   wire logic ignore_in = hold_cnt_r >= IGN_W;
   wire logic cap_edge  = ctrl_r.edge_sel ? wclk_rise : wclk_fall;
   wire logic send_sync = sync_req
                          | (sync_act_r & (sent_cnt_r < SMIN_W));
   // Edge switch mid-frame drops a word rather than cut a frame
   wire logic tx_idle   = busy_cnt_r == 3'd0;
   wire logic launch    = cap_edge & tx_ready & ctrl_r.tx_wake
                          & tx_idle;
   // Start bit in bit 0, stop bit on top, sent low bits first
   wire logic [11:0] data_frame = {1'b0, din_s, 1'b1};
   wire logic [11:0] next_frame = send_sync ? `TBSL_SYNC_FRAME
                                            : data_frame;
   wire logic line_on = ctrl_r.line_driver_enable & ctrl_r.tx_wake & tx_ready;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         init_cnt_r <= INIT_W;
         hold_cnt_r <= 3'd0;
         sent_cnt_r <= 11'd0;
         sync_act_r <= 1'b0;
         tx_sh_r    <= 12'h000;
         busy_cnt_r <= 3'd0;
      end else if (!ctrl_r.tx_wake) begin
         // Sleep: clock loop stopped, reinit on wake
         init_cnt_r <= INIT_W;
         hold_cnt_r <= 3'd0;
         sent_cnt_r <= 11'd0;
         sync_act_r <= 1'b0;
         tx_sh_r    <= 12'h000;
         busy_cnt_r <= 3'd0;
      end else begin
         if (wclk_rise && !tx_ready) begin
            init_cnt_r <= init_cnt_r - 11'd1;
         end
         if (!sync_req) begin
            hold_cnt_r <= 3'd0;
         end else if (wclk_rise && !ignore_in) begin
            hold_cnt_r <= hold_cnt_r + 3'd1;
         end
         if (launch) begin
            // Fresh frame each word cycle; gap bits idle low
            tx_sh_r    <= next_frame;
            busy_cnt_r <= FRAME_W;
            sync_act_r <= send_sync;
            if (!send_sync) begin
               sent_cnt_r <= 11'd0;
            end else if (sent_cnt_r < SMIN_W) begin
               sent_cnt_r <= sent_cnt_r + 11'd1;
            end
         end else begin
            tx_sh_r <= {2'b00, tx_sh_r[11:2]};
            if (!tx_idle) begin
               busy_cnt_r <= busy_cnt_r - 3'd1;
            end
         end
      end
   end

   // Line driver: two bits per core clock, bit 0 earlier in time
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         serial_pos_o <= 2'b00;
         serial_neg_o <= 2'b11;
         serial_oe_o  <= 1'b0;
      end else begin
         serial_pos_o <= tx_sh_r[1:0];
         serial_neg_o <= ~tx_sh_r[1:0];
         serial_oe_o  <= line_on;
      end
   end

   // Deserializer
   tbsl_rx_state_t rx_st_r;
   tbsl_rx_state_t rx_st_nxt;
   tbsl_rx_t       rx_r;
   tbsl_rx_t       rx_mid;
   tbsl_rx_t       rx_fin;
   logic [7:0]     ref_cnt_r;
   logic [3:0]     good_cnt_r;
   logic [7:0]     gap_cnt_r;
   logic [1:0]     stb_cnt_r;

   assign rx_mid = rx_step(rx_r, ser_in_s[0]);
   assign rx_fin = rx_step(rx_mid, ser_in_s[1]);
   wire logic rx_done = rx_mid.done | rx_fin.done;
   wire logic rx_bad  = rx_mid.bad | rx_fin.bad;
   wire logic is_sync = rx_fin.data == `TBSL_SYNC_WORD;
   wire logic rx_down = ~ctrl_r.rx_wake & ~ctrl_r.rx_oe;
   wire logic gap_out = gap_cnt_r >= LOSS_W;
   wire logic locked  = rx_st_r == RX_LOCKED;

   always_comb begin
      rx_st_nxt = rx_st_r;
      unique case (rx_st_r)
         RX_DOWN: begin
            rx_st_nxt = RX_REF;
         end
         RX_REF: begin
            if (ref_cnt_r >= REF_W) begin
               rx_st_nxt = RX_HUNT;
            end
         end
         RX_HUNT: begin
            if (rx_done && is_sync && good_cnt_r + 4'd1 >= LOCK_W) begin
               rx_st_nxt = RX_LOCKED;
            end
         end
         RX_LOCKED: begin
            if (rx_bad || gap_out) begin
               rx_st_nxt = RX_HUNT;
            end
         end
         default: begin
            rx_st_nxt = RX_DOWN;
         end
      endcase
      if (rx_down) begin
         rx_st_nxt = RX_DOWN;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rx_st_r    <= RX_DOWN;
         rx_r       <= '0;
         ref_cnt_r  <= 8'd0;
         good_cnt_r <= 4'd0;
         gap_cnt_r  <= 8'd0;
      end else begin
         rx_st_r <= rx_st_nxt;
         rx_r    <= rx_fin;
         if (rx_st_r != RX_REF) begin
            ref_cnt_r <= 8'd0;
         end else if (rclk_rise) begin
            ref_cnt_r <= ref_cnt_r + 8'd1;
         end
         if (rx_st_r != RX_HUNT || rx_bad || (rx_done && !is_sync)) begin
            good_cnt_r <= 4'd0;
         end else if (rx_done) begin
            good_cnt_r <= good_cnt_r + 4'd1;
         end
         if (rx_done || !locked) begin
            gap_cnt_r <= 8'd0;
         end else if (!gap_out) begin
            gap_cnt_r <= gap_cnt_r + 8'd1;
         end
      end
   end

   // Receiver outputs; word moves only while locked
   wire logic new_word = locked & rx_done & (rx_st_nxt == RX_LOCKED);
   wire logic stb_raw  = stb_cnt_r != 2'd0;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         parallel_output_word_o <= 10'h000;
         rx_last_r              <= 10'h000;
         stb_cnt_r              <= 2'd0;
         word_strobe_o          <= 1'b0;
         rx_data_oe_o           <= 1'b0;
         lock_n_o               <= 1'b1;
         lock_oe_o              <= 1'b0;
      end else begin
         if (new_word) begin
            parallel_output_word_o <= rx_fin.data;
            rx_last_r              <= rx_fin.data;
         end
         if (new_word) begin
            stb_cnt_r <= STB_W;
         end else if (stb_raw) begin
            stb_cnt_r <= stb_cnt_r - 2'd1;
         end
         // Polarity low inverts so the active edge falls
         word_strobe_o <= stb_raw ^ ~ctrl_r.stb_pol;
         rx_data_oe_o  <= ctrl_r.rx_oe & (rx_st_nxt == RX_LOCKED);
         lock_n_o      <= rx_st_nxt != RX_LOCKED;
         lock_oe_o     <= ctrl_r.rx_oe;
      end
   end

   always_comb begin
      status_w = 32'h0000_0000;
      status_w[`TBSL_STAT_TX_READY] = tx_ready;
      status_w[`TBSL_STAT_TX_SYNC]  = sync_act_r;
      status_w[`TBSL_STAT_REF_LOCK] = rx_st_r[2] | rx_st_r[3];
      status_w[`TBSL_STAT_RX_LOCK]  = locked;
      status_w[`TBSL_STAT_IGNORE]   = ignore_in;
      status_w[`TBSL_STAT_CNT_LSB +: 11] = sent_cnt_r;
   end

endmodule

`default_nettype wire

// ### bench/tbsl_props.sv
`timescale 1ns/1ns
`default_nettype none
module tbsl_props (
   input wire logic        core_clk_i,
   input wire logic        reset_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic [1:0]  serial_pos_o,
   input wire logic        serial_oe_o,
   input wire logic        word_strobe_o,
   input wire logic        rx_data_oe_o,
   input wire logic        lock_n_o
);
   logic [2:0] ph_r;
   logic [1:0] last_r;
   // Frame starts after an idle pair; words are picked without inner 00
   wire start_w = serial_oe_o && ph_r == 3'h0 && last_r == 2'h0
                  && serial_pos_o != 2'h0;
   always_ff @(posedge core_clk_i) begin
      last_r <= serial_pos_o;
      if (reset_i || !serial_oe_o) ph_r <= 3'h0;
      else if (start_w || ph_r != 3'h0)
         ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   ready_one_a: assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   setup_ready_a: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no pready after setup");
   err_ready_a: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");
   rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
      else $error("read data outside access");
   start_first_a: assert property (start_w |-> serial_pos_o[0])
      else $error("frame does not open with start bit");
   stop_last_a: assert property (ph_r == 3'h5 |-> !serial_pos_o[1])
      else $error("stop bit not low");
   idle_gap_a: assert property (ph_r == 3'h5 ##1 serial_oe_o
      |-> serial_pos_o == 2'h0)
      else $error("line not idle after frame");
   valid_lock_a: assert property (rx_data_oe_o |-> !lock_n_o)
      else $error("word driven while unlocked");
   strobe_width_a: assert property (rx_data_oe_o
      && $changed(word_strobe_o) |=> $stable(word_strobe_o))
      else $error("strobe level shorter than two cycles");
   cover property (start_w && serial_pos_o == 2'h3);
   cover property (!lock_n_o && rx_data_oe_o);
   cover property (pslverr_o);
endmodule
bind tbsl_top tbsl_props u_tbsl_props (.core_clk_i(core_clk_i),
   .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .serial_pos_o(serial_pos_o), .serial_oe_o(serial_oe_o),
   .word_strobe_o(word_strobe_o), .rx_data_oe_o(rx_data_oe_o),
   .lock_n_o(lock_n_o));
`default_nettype wire

// ### bench/tbsl_source.sv
`timescale 1ns/1ns
`default_nettype none
module tbsl_source #(
   parameter int REF_HALF_NS = 50
) (
   input  wire logic       core_clk_i,
   input  wire logic [9:0] word_hi_i,
   input  wire logic [9:0] word_lo_i,
   input  wire logic [1:0] serial_pos_i,
   input  wire logic       serial_oe_i,
   output var  logic       tx_word_clock_o,
   output var  logic       ref_clock_o,
   output var  logic [9:0] word_o,
   output var  logic [1:0] line_o
);
   logic [1:0] last_r = 2'h3;
   // Word changes mid-phase, so each capture edge sees one fixed value
   initial begin
      word_o = 10'h000;
      tx_word_clock_o = 1'b0;
      #7;
      forever begin
         // Word period scaled to eight core cycles
         tx_word_clock_o = 1'b1;
         #40 word_o = word_hi_i;
         #40 tx_word_clock_o = 1'b0;
         #40 word_o = word_lo_i;
         #40;
      end
   end
   initial begin
      ref_clock_o = 1'b0;
      forever #(REF_HALF_NS) ref_clock_o = ~ref_clock_o;
   end
   // Released line rests at the inverse of the last driven bit
   always @(posedge core_clk_i) if (serial_oe_i) last_r <= serial_pos_i;
   assign line_o = serial_oe_i ? serial_pos_i : {2{~last_r[1]}};
endmodule
`default_nettype wire

// ### bench/tbsl_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tbsl_params.svh"
module tbsl_top_tb;
   localparam int INIT = 8;
   localparam int SMIN = 4;
   logic        clk, rst, psel, pen, pwr, pready, perr, wclk, rclk;
   logic        soe, stb, rxoe, lock_n, lock_oe, e;
   logic [11:0] paddr, fr;
   logic [31:0] pwdata, prdata, q;
   logic [9:0]  din, dout, whi, wlo;
   logic [1:0]  spos, sneg, sin;
   time         t0, tp;
   int          mismatches, cmp_count, n;

   tbsl_top #(.INIT_WORDS(INIT), .SYNC_MIN(SMIN), .REF_EDGES(4),
      .LOCK_FRAMES(2), .LOSS_CYCLES(32)) u_tbsl_top (
      .core_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
      .tx_word_clock_i(wclk), .parallel_input_word_i(din),
      .serial_pos_o(spos), .serial_neg_o(sneg), .serial_oe_o(soe),
      .local_reference_clock_i(rclk), .serial_in_i(sin),
      .parallel_output_word_o(dout), .word_strobe_o(stb),
      .rx_data_oe_o(rxoe), .lock_n_o(lock_n), .lock_oe_o(lock_oe));
   tbsl_source u_tbsl_source (.core_clk_i(clk), .word_hi_i(whi),
      .word_lo_i(wlo), .serial_pos_i(spos), .serial_oe_i(soe),
      .tx_word_clock_o(wclk), .ref_clock_o(rclk), .word_o(din),
      .line_o(sin));

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic chb(input logic g, input logic x);
      chk({31'h0000_0000, g}, {31'h0000_0000, x});
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = perr;
      psel <= 1'b0; pen <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x,
                     input logic xe);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, x);
      chb(e, xe);
   endtask
   task automatic frame(output logic [11:0] f);
      logic [1:0] p;
      p = 2'h3;
      for (int i = 0; i < 100 && !(soe === 1'b1 && p === 2'h0
           && spos !== 2'h0); i++) begin
         p = spos;
         @(negedge clk);
      end
      t0 = $time;
      for (int i = 0; i < 6; i++) begin
         f[2*i +: 2] = spos;
         @(negedge clk);
      end
   endtask
   task automatic pulse(input logic act);
      for (n = 0; n < 20 && stb !== ~act; n++) @(negedge clk);
      for (n = 0; n < 20 && stb !== act; n++) @(negedge clk);
      @(negedge clk);
      chb(stb, act);
      @(negedge clk);
      chb(stb, ~act);
   endtask
   task automatic give_verdict;
      if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #400_000;
      mismatches++;
      give_verdict;
   end
   initial begin
      rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0;
      paddr = 12'h000; pwdata = 32'h0000_0000;
      whi = 10'h2AA; wlo = 10'h155; mismatches = 0; cmp_count = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(`TBSL_ADDR_CTRL, 32'h0000_0079, 1'b0);
      rd(12'h00C, 32'h0000_0000, 1'b1);
      chb(soe, 1'b0);
      chb(lock_n, 1'b1);
      chb(stb, 1'b1);
      apb(1'b1, `TBSL_ADDR_CTRL, 32'h0000_00FB);
      repeat ((INIT - 3) * 8) @(negedge clk);
      chb(soe, 1'b0);
      for (n = 0; n < 48 && soe !== 1'b1; n++) @(negedge clk);
      chb(soe, 1'b1);
      frame(fr);
      chk({20'h0_0000, fr}, 32'h0000_003F);
      chk({30'h0000_0000, sneg}, {30'h0000_0000, ~spos});
      tp = t0;
      frame(fr);
      chk(32'(t0 - tp), 32'h0000_00A0);
      apb(1'b0, `TBSL_ADDR_STATUS, 32'h0000_0000);
      chb(q[4], 1'b1);
      for (n = 0; n < 600 && lock_n !== 1'b0; n++) @(negedge clk);
      chb(lock_n, 1'b0);
      chb(rxoe, 1'b1);
      repeat (2 * SMIN * 8) @(negedge clk);
      frame(fr);
      chk({20'h0_0000, fr}, 32'h0000_003F);
      apb(1'b1, `TBSL_ADDR_CTRL, 32'h0000_00F9);
      repeat (24) @(negedge clk);
      frame(fr);
      chk({20'h0_0000, fr}, {20'h0_0000, 1'b0, wlo, 1'b1});
      repeat (16) @(negedge clk);
      chk({22'h00_0000, dout}, {22'h00_0000, wlo});
      pulse(1'b1);
      rd(`TBSL_ADDR_RXWORD, {22'h00_0000, wlo}, 1'b0);
      apb(1'b1, `TBSL_ADDR_CTRL, 32'h0000_00F8);
      repeat (32) @(negedge clk);
      chk({22'h00_0000, dout}, {22'h00_0000, whi});
      apb(1'b1, `TBSL_ADDR_CTRL, 32'h0000_0030);
      repeat (4) @(negedge clk);
      chb(rxoe, 1'b0);
      chb(lock_oe, 1'b0);
      chb(soe, 1'b0);
      apb(1'b1, `TBSL_ADDR_CTRL, 32'h0000_0070);
      for (n = 0; n < 200 && lock_n !== 1'b1; n++) @(negedge clk);
      chb(lock_n, 1'b1);
      chb(rxoe, 1'b0);
      apb(1'b1, `TBSL_ADDR_CTRL, 32'h0000_0078);
      repeat (24) @(negedge clk);
      chb(soe, 1'b1);
      // Lock lost above, so the system asks for sync again
      apb(1'b1, `TBSL_ADDR_CTRL, 32'h0000_007C);
      for (n = 0; n < 600 && lock_n !== 1'b0; n++) @(negedge clk);
      chb(lock_n, 1'b0);
      pulse(1'b0);
      repeat (2 * SMIN * 8) @(negedge clk);
      apb(1'b1, `TBSL_ADDR_CTRL, 32'h0000_0008);
      repeat (8) @(negedge clk);
      chb(soe, 1'b0);
      chb(lock_oe, 1'b0);
      chb(rxoe, 1'b0);
      apb(1'b0, `TBSL_ADDR_STATUS, 32'h0000_0000);
      chb(q[0], 1'b0);
      apb(1'b1, `TBSL_ADDR_CTRL, 32'h0000_0078);
      repeat ((INIT - 3) * 8) @(negedge clk);
      chb(soe, 1'b0);
      chb(lock_n, 1'b1);
      for (n = 0; n < 48 && soe !== 1'b1; n++) @(negedge clk);
      chb(soe, 1'b1);
      give_verdict;
   end
endmodule
`default_nettype wire
